// ---- logic/hpcp_top.sv ----
// host serial port, interrupt, device reset and output gate pins
`timescale 1ns/1ns
`include "hpcp_regs.svh"
// How it works
// RQ1: a high select pin runs the port as I2C, a low one as SPI.
// RQ2: the data pin is open-drain I2C data, 3-wire SPI data, or 4-wire SPI input only.
// RQ3: in 4-wire SPI the second shared pin carries read data out to the host.
// RQ4: in I2C the two address pins set the low address bits and only that address is answered.
// RQ5: all serial timing comes from edges of the host-driven serial clock.
// RQ6: in SPI the address-zero pin is an active-low select; nothing moves while it is high.
// RQ7: the interrupt pin goes low when any monitored status bit changes.
// RQ8: a low device reset returns all logic and masks to their defaults.
// RQ9: every clock output stays disabled while the device reset is held.
// RQ10: each gate pin, when high, disables the outputs chosen by its own mask.
// RQ11: after reset the first gate pin covers all outputs and the other two none.
// RQ12: in 4-wire SPI the serial output floats whenever chip select is high.
module hpcp_top #(
  parameter logic [4:0] I2C_ADDR_HI = `HPCP_I2C_HI_RST
) (
  input  wire logic                    CORE_CLK,
  input  wire logic                    RST_N,
  input  wire logic                    DEVICE_RESET_N,
  input  wire logic                    IFACE_SEL_I2C,
  input  wire logic                    SPI_FOUR_WIRE,
  input  wire logic                    SPI_SDIO_DRIVE,
  input  wire logic                    SERIAL_CLK,
  input  wire logic                    SERIAL_DATA_IN,
  output wire logic                    SERIAL_DATA_OUT,
  output wire logic                    SERIAL_DATA_OE,
  input  wire logic                    ADDR_ONE_OR_SERIAL_OUT_IN,
  output wire logic                    ADDR_ONE_OR_SERIAL_OUT_OUT,
  output wire logic                    ADDR_ONE_OR_SERIAL_OUT_OE,
  input  wire logic                    ADDR_ZERO_OR_CHIP_SELECT_N,
  input  wire logic                    OUT_GATE_N_0,
  input  wire logic                    OUT_GATE_N_1,
  input  wire logic                    OUT_GATE_N_2,
  output hpcp_pkg::hpcp_rx_s           RX_BYTE,
  input  wire logic [7:0]              TX_DATA,
  output wire logic                    TX_TAKEN,
  input  wire logic [`HPCP_N_GATE-1:0] MASK_WR,
  input  wire logic [`HPCP_N_OUT-1:0]  MASK_DATA,
  input  wire logic [`HPCP_N_STAT-1:0] STATUS_IN,
  input  wire logic                    IRQ_ACK,
  output wire logic                    STATUS_CHANGE_IRQ_N,
  output wire logic [`HPCP_N_OUT-1:0]  CLK_OUT_EN
);

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  logic [`HPCP_N_PIN-1:0]  pin;
  logic                    scl;
  logic                    sda;
  logic                    cs_n;
  logic                    i2c;
  logic [`HPCP_N_GATE-1:0] gate;
  logic                    rst;

  hpcp_sync2 #(
    .W       (`HPCP_N_PIN),
    .RST_VAL (`HPCP_SYNC_RST)
  ) u_sync (
    .CORE_CLK (CORE_CLK),
    .RST_N    (RST_N),
    .D        ({DEVICE_RESET_N, OUT_GATE_N_2, OUT_GATE_N_1, OUT_GATE_N_0, IFACE_SEL_I2C,
                ADDR_ZERO_OR_CHIP_SELECT_N, ADDR_ONE_OR_SERIAL_OUT_IN, SERIAL_DATA_IN,
                SERIAL_CLK}),
    .Q        (pin)
  );

  assign scl  = pin[`HPCP_PIN_SCLK];
  assign sda  = pin[`HPCP_PIN_SDA];
  assign cs_n = pin[`HPCP_PIN_A0CS];
  assign i2c  = pin[`HPCP_PIN_SEL];
  assign gate = pin[`HPCP_PIN_GATE +: `HPCP_N_GATE];
  assign rst  = !RST_N || !pin[`HPCP_PIN_RST];

  // ************************************************************
  // next state
  // ************************************************************
  hpcp_pkg::hpcp_state_s s;
  hpcp_pkg::hpcp_state_s next_s;
  logic                  rise;
  logic                  fall;
  logic                  start;
  logic                  stop;
  logic [6:0]            my_addr;
  logic [7:0]            rx_in;
  logic [`HPCP_N_OUT-1:0] blocked;

  always_comb begin
    next_s          = s;
    next_s.rxo      = '0;
    next_s.tx_taken = 1'h0;
    next_s.scl_q    = scl;
    next_s.sda_q    = sda;
    rise            = scl && !s.scl_q;                          // see RQ5
    fall            = !scl && s.scl_q;                          // see RQ5
    start           = scl && s.scl_q && s.sda_q && !sda;
    stop            = scl && s.scl_q && !s.sda_q && sda;
    my_addr         = {I2C_ADDR_HI, pin[`HPCP_PIN_A1], cs_n};    // see RQ4
    rx_in           = {s.rx[6:0], sda};
    blocked         = '0;

    // status change is sticky; a change in the ack cycle wins over the ack
    next_s.stat_q = STATUS_IN;
    if (IRQ_ACK) begin
      next_s.irq = 1'h0;
    end
    if (|(STATUS_IN ^ s.stat_q)) begin
      next_s.irq = 1'h1;                                        // see RQ7
    end

    for (int k = 0; k < `HPCP_N_GATE; k++) begin
      if (MASK_WR[k]) begin
        next_s.mask[k] = MASK_DATA;
      end
      if (gate[k]) begin
        blocked = blocked | s.mask[k];                          // see RQ10
      end
    end
    next_s.out_en = ~blocked;

    if (!i2c) begin                                             // see RQ1
      // spi mode 0: sample on rise, shift out on fall
      if (cs_n) begin                                           // see RQ6
        next_s.st     = hpcp_pkg::ST_IDLE;
        next_s.cnt    = '0;
        next_s.reload = 1'h1;
      end else begin
        next_s.st = hpcp_pkg::ST_SPI;
        if (s.reload) begin
          next_s.tx       = TX_DATA;
          next_s.tx_taken = 1'h1;
          next_s.reload   = 1'h0;
          if (s.st == hpcp_pkg::ST_IDLE) begin
            next_s.first = 1'h1;
          end
        end else if (rise) begin
          next_s.rx  = rx_in;
          next_s.cnt = s.cnt + 4'h1;
          if (s.cnt == 4'h7) begin
            next_s.rxo    = '{valid: 1'h1, first: s.first, data: rx_in};
            next_s.first  = 1'h0;
            next_s.cnt    = '0;
            next_s.reload = 1'h1;
          end
        end else if (fall && s.cnt != 4'h0) begin
          next_s.tx = {s.tx[6:0], 1'h0};
        end
      end
      next_s.sda_o  = next_s.tx[7];
      next_s.sda_oe = !SPI_FOUR_WIRE && !cs_n && SPI_SDIO_DRIVE; // see RQ2
      next_s.sdo    = next_s.tx[7];                             // see RQ3
      next_s.sdo_oe = SPI_FOUR_WIRE && !cs_n;                   // see RQ12
    end else begin
      next_s.sda_o  = 1'h0;
      next_s.sdo    = 1'h0;
      next_s.sdo_oe = 1'h0;                                     // see RQ4
      if (start) begin
        next_s.st     = hpcp_pkg::ST_ADDR;
        next_s.cnt    = '0;
        next_s.sda_oe = 1'h0;
      end else if (stop) begin
        next_s.st     = hpcp_pkg::ST_IDLE;
        next_s.sda_oe = 1'h0;
      end else begin
        case (s.st)
          hpcp_pkg::ST_ADDR, hpcp_pkg::ST_WR: begin
            if (rise) begin
              next_s.rx  = rx_in;
              next_s.cnt = s.cnt + 4'h1;
            end else if (fall && s.cnt == `HPCP_BIT_LAST) begin
              if (s.st == hpcp_pkg::ST_WR) begin
                next_s.rxo    = '{valid: 1'h1, first: s.first, data: s.rx};
                next_s.first  = 1'h0;
                next_s.sda_oe = 1'h1;
                next_s.st     = hpcp_pkg::ST_WR_ACK;
              end else if (s.rx[7:1] == my_addr) begin           // see RQ4
                next_s.sda_oe = 1'h1;
                next_s.rw     = s.rx[0];
                next_s.first  = 1'h1;
                next_s.st     = hpcp_pkg::ST_ADDR_ACK;
              end else begin
                next_s.st = hpcp_pkg::ST_IDLE;
              end
            end
          end
          hpcp_pkg::ST_ADDR_ACK, hpcp_pkg::ST_WR_ACK: begin
            if (fall) begin
              next_s.cnt = '0;
              if (s.st == hpcp_pkg::ST_ADDR_ACK && s.rw) begin
                next_s.tx       = TX_DATA;
                next_s.tx_taken = 1'h1;
                next_s.sda_oe   = !TX_DATA[7];                  // see RQ2
                next_s.st       = hpcp_pkg::ST_RD;
              end else begin
                next_s.sda_oe = 1'h0;
                next_s.st     = hpcp_pkg::ST_WR;
              end
            end
          end
          hpcp_pkg::ST_RD: begin
            if (rise) begin
              next_s.cnt = s.cnt + 4'h1;
            end else if (fall && s.cnt == `HPCP_BIT_LAST) begin
              next_s.sda_oe = 1'h0;
              next_s.st     = hpcp_pkg::ST_RD_ACK;
            end else if (fall) begin
              next_s.tx     = {s.tx[6:0], 1'h0};
              next_s.sda_oe = !s.tx[6];
            end
          end
          hpcp_pkg::ST_RD_ACK: begin
            // a released line here is a nack and ends the read
            if (rise) begin
              next_s.reload = !sda;
              if (sda) begin
                next_s.st = hpcp_pkg::ST_IDLE;
              end
            end else if (fall && s.reload) begin
              next_s.tx       = TX_DATA;
              next_s.tx_taken = 1'h1;
              next_s.sda_oe   = !TX_DATA[7];
              next_s.reload   = 1'h0;
              next_s.cnt      = '0;
              next_s.st       = hpcp_pkg::ST_RD;
            end
          end
          default: begin
            next_s.st     = hpcp_pkg::ST_IDLE;
            next_s.sda_oe = 1'h0;
          end
        endcase
      end
    end

    if (rst) begin                                              // see RQ8
      next_s         = '0;
      next_s.st      = hpcp_pkg::ST_IDLE;
      next_s.scl_q   = 1'h1;
      next_s.sda_q   = 1'h1;
      next_s.reload  = 1'h1;
      next_s.stat_q  = STATUS_IN;
      next_s.mask[0] = '1;                                      // see RQ11
      next_s.out_en  = '0;                                      // see RQ9
    end
  end

  always_ff @(posedge CORE_CLK) begin
    s <= next_s;
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign SERIAL_DATA_OUT            = s.sda_o;
  assign SERIAL_DATA_OE             = s.sda_oe;
  assign ADDR_ONE_OR_SERIAL_OUT_OUT = s.sdo;
  assign ADDR_ONE_OR_SERIAL_OUT_OE  = s.sdo_oe;
  assign RX_BYTE                    = s.rxo;
  assign TX_TAKEN                   = s.tx_taken;
  assign STATUS_CHANGE_IRQ_N        = !s.irq;
  assign CLK_OUT_EN                 = s.out_en;

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);

  sequence s_dev_rst;
    !pin[`HPCP_PIN_RST];
  endsequence

  sequence s_spi4_idle;
    !i2c && SPI_FOUR_WIRE && cs_n;
  endsequence

  reset_out_off_a: assert property (s_dev_rst |=> CLK_OUT_EN == '0) // see RQ9
    else $error("clock outputs enabled during device reset");
  reset_mask_a: assert property (s_dev_rst |=> // see RQ11
    s.mask[0] == '1 && s.mask[1] == '0 && s.mask[2] == '0)
    else $error("gate masks not at defaults after reset");
  // a mask write in the same cycle only takes effect one edge later
  gate_block_a: assert property (!rst && gate[1] && !MASK_WR[1] ##1 !rst |-> // see RQ10
    (CLK_OUT_EN & s.mask[1]) == '0)
    else $error("gated output still enabled");
  irq_on_change_a: assert property (!rst && STATUS_IN != $past(STATUS_IN) |=> // see RQ7
    !STATUS_CHANGE_IRQ_N)
    else $error("status change did not raise interrupt");
  irq_hold_a: assert property (!rst && !STATUS_CHANGE_IRQ_N && !IRQ_ACK |=> // see RQ7
    !STATUS_CHANGE_IRQ_N)
    else $error("interrupt dropped without ack");
  sdo_release_a: assert property (s_spi4_idle |=> !ADDR_ONE_OR_SERIAL_OUT_OE) // see RQ12
    else $error("serial output driven with chip select high");
  sdo_drive_a: assert property (!rst && !i2c && SPI_FOUR_WIRE && !cs_n |=> // see RQ3
    ADDR_ONE_OR_SERIAL_OUT_OE)
    else $error("serial output not driven during selected transfer");
  sdi_input_a: assert property (!i2c && SPI_FOUR_WIRE |=> !SERIAL_DATA_OE) // see RQ2
    else $error("data pin driven in 4-wire mode");
  i2c_addr_pin_a: assert property (i2c |=> !ADDR_ONE_OR_SERIAL_OUT_OE) // see RQ4
    else $error("address pin driven in I2C mode");
  addr_match_a: assert property (s.st == hpcp_pkg::ST_ADDR_ACK |-> // see RQ4
    s.rx[7:1] == my_addr)
    else $error("acknowledged a foreign address");
  cs_quiet_a: assert property ((!i2c && cs_n) [*2] |=> !RX_BYTE.valid && s.cnt == '0) // see RQ6
    else $error("transfer activity without chip select");
  mode_spi_a: assert property (!i2c |=> // see RQ1
    s.st == hpcp_pkg::ST_IDLE || s.st == hpcp_pkg::ST_SPI)
    else $error("I2C state reached in SPI mode");

endmodule

// ---- logic/hpcp_regs.svh ----
// constants for the host port and control pin block
`ifndef HPCP_REGS_SVH
`define HPCP_REGS_SVH

// ************************************************************
// sizes
// ************************************************************
`define HPCP_N_OUT      7
`define HPCP_N_STAT     8
`define HPCP_N_GATE     3
`define HPCP_N_PIN      9

// ************************************************************
// positions in the synchronised pin bus
// ************************************************************
`define HPCP_PIN_SCLK   0
`define HPCP_PIN_SDA    1
`define HPCP_PIN_A1     2
`define HPCP_PIN_A0CS   3
`define HPCP_PIN_SEL    4
`define HPCP_PIN_GATE   5
`define HPCP_PIN_RST    8

// ************************************************************
// reset values and the last bit count
// ************************************************************
// idle level of each pin: pulled-up lines high, gate pins low
`define HPCP_SYNC_RST   9'h11F
// upper five bits of the bus address, value arbitrary
`define HPCP_I2C_HI_RST 5'h1A
`define HPCP_BIT_LAST   4'h8

`endif

// ---- logic/hpcp_pkg.sv ----
// types for the host port and control pin block
`include "hpcp_regs.svh"
package hpcp_pkg;

  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_WR, ST_WR_ACK, ST_RD, ST_RD_ACK, ST_SPI
  } hpcp_st_e;

  typedef struct packed {
    logic       valid;
    logic       first;
    logic [7:0] data;
  } hpcp_rx_s;

  typedef struct packed {
    hpcp_st_e                                   st;
    logic [3:0]                                 cnt;
    logic [7:0]                                 rx;
    logic [7:0]                                 tx;
    logic                                       rw;
    logic                                       reload;
    logic                                       first;
    logic                                       scl_q;
    logic                                       sda_q;
    logic                                       sda_o;
    logic                                       sda_oe;
    logic                                       sdo;
    logic                                       sdo_oe;
    logic                                       tx_taken;
    hpcp_rx_s                                   rxo;
    logic [`HPCP_N_STAT-1:0]                    stat_q;
    logic                                       irq;
    logic [`HPCP_N_GATE-1:0][`HPCP_N_OUT-1:0]   mask;
    logic [`HPCP_N_OUT-1:0]                     out_en;
  } hpcp_state_s;

  typedef struct packed {
    logic ff1;
    logic ff2;
  } hpcp_sync_s;

endpackage

// ---- logic/hpcp_sync2.sv ----
// two-flop synchroniser, one per pin
`timescale 1ns/1ns
module hpcp_sync2 #(
  parameter int              W       = 1,
  parameter logic [W-1:0]    RST_VAL = '0
) (
  input  wire logic          CORE_CLK,
  input  wire logic          RST_N,
  input  wire logic [W-1:0]  D,
  output wire logic [W-1:0]  Q
);

  // ************************************************************
  // one stage pair per bit
  // ************************************************************
  for (genvar i = 0; i < W; i++) begin : g_bit
    hpcp_pkg::hpcp_sync_s s;
    hpcp_pkg::hpcp_sync_s next_s;
    always_comb begin
      next_s.ff1 = D[i];
      next_s.ff2 = s.ff1;
      if (!RST_N) begin
        next_s.ff1 = RST_VAL[i];
        next_s.ff2 = RST_VAL[i];
      end
    end
    always_ff @(posedge CORE_CLK) begin
      s <= next_s;
    end
    assign Q[i] = s.ff2;
  end

endmodule

// ---- tb/hpcp_host.sv ----
// host controller model: SPI mode 0 and I2C master on the serial pins
`timescale 1ns/1ns
module hpcp_host (
  input  wire logic CORE_CLK,
  input  wire logic sda_line,
  input  wire logic sdo_line,
  output logic      sclk,
  output logic      cs_n,
  output logic      h_d,
  output logic      h_oe
);
  // ********************
  // link tasks, entered and left on a clock edge
  // ********************
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    h_d  = 1'b0;
    h_oe = 1'b0;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge CORE_CLK);
  endtask
  // select is held 8 cycles here, 12 before the first rise of spi_byte; data line shows the inverse when released
  task automatic sel(input logic v);
    cs_n <= v;
    h_d  <= ~h_d;
    cyc(8);
  endtask
  // clock stands still between frames: high for I2C, low for SPI
  task automatic idle(input logic i2c);
    sclk <= i2c;
    h_oe <= 1'b0;
    cyc(8);
  endtask
  // 4 cycles low, 4 high: the 400 ns link period
  task automatic spi_byte(input logic [7:0] tx, input logic four, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      h_d  <= tx[i];
      cyc(4);
      sclk <= 1'b1;
      rx[i] = four ? sdo_line : sda_line;
      cyc(4);
      sclk <= 1'b0;
    end
    cyc(4);
  endtask
  // open drain: h_oe pulls the data line low
  task automatic i2c_start();
    h_oe <= 1'b1;
    cyc(4);
  endtask
  task automatic i2c_stop();
    sclk <= 1'b0;
    cyc(2);
    h_oe <= 1'b1;
    cyc(2);
    sclk <= 1'b1;
    cyc(4);
    h_oe <= 1'b0;
    cyc(4);
  endtask
  task automatic i2c_bit(input logic b, output logic r);
    sclk <= 1'b0;
    cyc(2);
    h_oe <= ~b;
    cyc(2);
    sclk <= 1'b1;
    cyc(2);
    r = sda_line;
    cyc(2);
  endtask
  task automatic i2c_byte(input logic [7:0] b, output logic [7:0] r);
    for (int i = 7; i >= 0; i--) begin
      i2c_bit(b[i], r[i]);
    end
  endtask
endmodule

// ---- tb/tb_host_port_and_control_pins.sv ----
// self-checking bench for the host port and control pin block
`timescale 1ns/1ns
`include "hpcp_regs.svh"
module tb_host_port_and_control_pins;
  logic               clk = 1'b0, rst_n = 1'b0, dev_rst_n = 1'b1, sel_i2c = 1'b0;
  logic               four = 1'b1, sdio_drv = 1'b0, a1_strap = 1'b1, irq_ack = 1'b0;
  logic [2:0]         gate = 3'h0, mask_wr = 3'h0;
  logic [6:0]         mask_data = 7'h00;
  logic [7:0]         tx_data = 8'h00, status = 8'h00, rx_last;
  logic               rx_first, do_o, do_oe, a1_o, a1_oe, tx_taken, irq_n, sclk, cs_n, h_d, h_oe;
  logic [6:0]         clk_en;
  hpcp_pkg::hpcp_rx_s rx;
  int                 rx_n = 0, err_total = 0, n_tests = 0, cycles = 0;
  // sda is pulled up in I2C; a1 sits at the a1_strap level when nobody drives it
  wire logic          sda_line = sel_i2c ? ~((do_oe & ~do_o) | h_oe) : (do_oe ? do_o : h_d);
  wire logic          sdo_line = a1_oe ? a1_o : a1_strap;

  hpcp_top u_hpcp_top (
    .CORE_CLK (clk), .RST_N (rst_n), .DEVICE_RESET_N (dev_rst_n), .IFACE_SEL_I2C (sel_i2c),
    .SPI_FOUR_WIRE (four), .SPI_SDIO_DRIVE (sdio_drv), .SERIAL_CLK (sclk),
    .SERIAL_DATA_IN (sda_line), .SERIAL_DATA_OUT (do_o), .SERIAL_DATA_OE (do_oe),
    .ADDR_ONE_OR_SERIAL_OUT_IN (sdo_line), .ADDR_ONE_OR_SERIAL_OUT_OUT (a1_o),
    .ADDR_ONE_OR_SERIAL_OUT_OE (a1_oe), .ADDR_ZERO_OR_CHIP_SELECT_N (cs_n),
    .OUT_GATE_N_0 (gate[0]), .OUT_GATE_N_1 (gate[1]), .OUT_GATE_N_2 (gate[2]),
    .RX_BYTE (rx), .TX_DATA (tx_data), .TX_TAKEN (tx_taken), .MASK_WR (mask_wr),
    .MASK_DATA (mask_data), .STATUS_IN (status), .IRQ_ACK (irq_ack),
    .STATUS_CHANGE_IRQ_N (irq_n), .CLK_OUT_EN (clk_en)
  );
  hpcp_host u_hpcp_host (
    .CORE_CLK (clk), .sda_line (sda_line), .sdo_line (sdo_line),
    .sclk (sclk), .cs_n (cs_n), .h_d (h_d), .h_oe (h_oe)
  );

  always #25 clk = ~clk;
  // ********************
  // monitors and checking
  // ********************
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (rx.valid === 1'b1) begin
      rx_n     <= rx_n + 1;
      rx_last  <= rx.data;
      rx_first <= rx.first;
    end
    // every load moves the byte on, so a lost or doubled load shows in the read data
    if (tx_taken === 1'b1) begin
      tx_data <= tx_data + 8'h11;
    end
    if (cycles == 20000) begin
      err_total++;
      summarize();
    end
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic ack_irq();
    irq_ack <= 1'b1;
    cyc(1);
    irq_ack <= 1'b0;
    cyc(2);
  endtask
  // ********************
  // scenarios
  // ********************
  task automatic t_gates();
    chk("irq after reset", irq_n, 1'b1);
    chk("outputs after reset", clk_en, 7'h7F);
    gate <= 3'b110;
    cyc(5);
    chk("gates 1 2 idle", clk_en, 7'h7F);
    gate <= 3'b111;
    cyc(5);
    chk("gate 0 all", clk_en, 7'h00);
    mask_wr   <= 3'b010;
    mask_data <= 7'h05;
    cyc(1);
    mask_wr   <= 3'b100;
    mask_data <= 7'h30;
    cyc(1);
    mask_wr <= 3'b000;
    gate    <= 3'b110;
    cyc(5);
    chk("masks 1 2", clk_en, 7'h4A);
    gate <= 3'b100;
    cyc(5);
    chk("mask 2", clk_en, 7'h4F);
    mask_wr   <= 3'b001;
    mask_data <= 7'h03;
    cyc(1);
    mask_wr <= 3'b000;
    gate    <= 3'b101;
    cyc(5);
    chk("mask 0", clk_en, 7'h4C);
    gate <= 3'b100;
  endtask
  task automatic t_dev_reset();
    status <= 8'h3C;
    cyc(1);
    dev_rst_n <= 1'b0;
    cyc(4);
    chk("off in reset", clk_en, 7'h00);
    cyc(20);
    chk("still off", clk_en, 7'h00);
    chk("irq reset", irq_n, 1'b1);
    dev_rst_n <= 1'b1;
    cyc(6);
    chk("default masks", clk_en, 7'h7F);
    gate <= 3'b000;
    cyc(4);
  endtask
  task automatic t_irq();
    ack_irq();
    chk("irq idle", irq_n, 1'b1);
    status <= 8'hBC;
    cyc(2);
    chk("irq on change", irq_n, 1'b0);
    cyc(6);
    chk("irq held", irq_n, 1'b0);
    ack_irq();
    chk("irq acked", irq_n, 1'b1);
  endtask
  task automatic t_spi();
    logic [7:0] rd;
    int         n0;
    tx_data  <= 8'hA5;
    sdio_drv <= 1'b1;
    u_hpcp_host.sel(1'b0);
    chk("sdo driven", a1_oe, 1'b1);
    u_hpcp_host.spi_byte(8'h3C, 1'b1, rd);
    chk("read 1", rd, 8'hA5);
    chk("sdi only", do_oe, 1'b0);
    chk("write 1", rx_last, 8'h3C);
    chk("first", rx_first, 1'b1);
    u_hpcp_host.spi_byte(8'hE1, 1'b1, rd);
    chk("read 2", rd, 8'hB6);
    chk("write 2", rx_last, 8'hE1);
    u_hpcp_host.sel(1'b1);
    chk("sdo released", a1_oe, 1'b0);
    n0 = rx_n;
    u_hpcp_host.spi_byte(8'h5A, 1'b1, rd);
    chk("no select rx", rx_n, n0);
    chk("no select sdo", rd, 8'hFF);
    four     <= 1'b0;
    sdio_drv <= 1'b0;
    tx_data  <= 8'hC3;
    u_hpcp_host.sel(1'b0);
    u_hpcp_host.spi_byte(8'h81, 1'b0, rd);
    chk("3-wire write", rx_last, 8'h81);
    chk("3-wire no sdo", a1_oe, 1'b0);
    sdio_drv <= 1'b1;
    cyc(4);
    chk("sdio driven", do_oe, 1'b1);
    u_hpcp_host.spi_byte(8'h00, 1'b0, rd);
    chk("3-wire read", rd, 8'hD4);
    sdio_drv <= 1'b0;
    u_hpcp_host.sel(1'b1);
    chk("sdio released", do_oe, 1'b0);
    four <= 1'b1;
  endtask
  task automatic t_i2c();
    logic [7:0] rd;
    logic       ack;
    u_hpcp_host.sel(1'b0);
    sel_i2c <= 1'b1;
    u_hpcp_host.idle(1'b1);
    u_hpcp_host.i2c_start();
    u_hpcp_host.i2c_byte({`HPCP_I2C_HI_RST, 2'b10, 1'b0}, rd);
    u_hpcp_host.i2c_bit(1'b1, ack);
    chk("addr ack", ack, 1'b0);
    u_hpcp_host.i2c_byte(8'h96, rd);
    u_hpcp_host.i2c_bit(1'b1, ack);
    u_hpcp_host.i2c_stop();
    chk("i2c write", rx_last, 8'h96);
    chk("i2c first", rx_first, 1'b1);
    u_hpcp_host.i2c_start();
    u_hpcp_host.i2c_byte({`HPCP_I2C_HI_RST, 2'b00, 1'b0}, rd);
    u_hpcp_host.i2c_bit(1'b1, ack);
    chk("other addr", ack, 1'b1);
    u_hpcp_host.i2c_stop();
    // the address pin strap moves the answered address
    a1_strap <= 1'b0;
    u_hpcp_host.i2c_start();
    u_hpcp_host.i2c_byte({`HPCP_I2C_HI_RST, 2'b00, 1'b0}, rd);
    u_hpcp_host.i2c_bit(1'b1, ack);
    chk("strap addr", ack, 1'b0);
    u_hpcp_host.i2c_stop();
    a1_strap <= 1'b1;
    tx_data  <= 8'h69;
    u_hpcp_host.i2c_start();
    u_hpcp_host.i2c_byte({`HPCP_I2C_HI_RST, 2'b10, 1'b1}, rd);
    u_hpcp_host.i2c_bit(1'b1, ack);
    chk("read addr ack", ack, 1'b0);
    u_hpcp_host.i2c_byte(8'hFF, rd);
    chk("i2c read", rd, 8'h69);
    u_hpcp_host.i2c_bit(1'b0, ack);
    u_hpcp_host.i2c_byte(8'hFF, rd);
    chk("i2c read 2", rd, 8'h7A);
    u_hpcp_host.i2c_bit(1'b1, ack);
    u_hpcp_host.i2c_stop();
  endtask
  initial begin
    cyc(6);
    rst_n <= 1'b1;
    cyc(6);
    t_gates();
    t_dev_reset();
    t_irq();
    t_spi();
    t_i2c();
    summarize();
  end
endmodule
